// *** src/frt_pkg.sv ***
// Package for the free-running match timer: register map, field layout, carriers
package frt_pkg;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 32;
	// Register byte offsets
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_PERIOD = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	// Mode register fields
	localparam int MODE_MIE = 0;
	localparam int MODE_OVERFLOW_IRQ_ENABLE = 1;
	localparam int MODE_MCD = 2;
	// Control register fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_HOLD = 1;
	localparam int CTRL_CLR = 2;
	localparam int CTRL_REQ = 3;
	// Status register fields
	localparam int ST_MATCH = 0;
	localparam int ST_OVF = 1;
	localparam int ST_ACK = 2;
	// Reset values and constants
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Register bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} frt_bus_t;
endpackage : frt_pkg

// *** src/frt_timer.sv ***
// Free-running 32-bit match timer with sticky event flags
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module frt_timer #(
	parameter int CNT_WIDTH = 32
) (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	// Timer tick, synchronous to clock
	input  wire logic                      tick,
	// Register bus
	input  wire frt_pkg::frt_bus_t         bus,
	output logic [31:0]                    rdata,
	// Events
	output logic                           irq,
	output logic                           wakeup
);
	import frt_pkg::*;

	logic [7:0]           mode_q, mode_d;
	logic [3:0]           ctrl_q, ctrl_d;
	logic [31:0]          period_q, period_d;
	logic [CNT_WIDTH-1:0] cnt_q, cnt_d;
	logic [31:0]          snap_q, snap_d;
	logic                 match_q, match_d;
	logic                 ovf_q, ovf_d;
	logic                 ack_q, ack_d;
	logic [31:0]          rdata_d;
	logic                 irq_d, wake_d;
	logic                 wrMode, wrCtrl, wrPeriod, wrStatus;
	logic                 hitMatch, hitOvf, matchHold;
	logic                 countTick;

	// Address decode of a write
	function automatic logic isWr(input frt_bus_t b, input logic [7:0] off);
		return b.wr && (b.addr == off);
	endfunction : isWr

	// Counter equality against a 32-bit setting, cut to the counter width
	function automatic logic atValue(input logic [CNT_WIDTH-1:0] c, input logic [31:0] v);
		return c == CNT_WIDTH'(v);
	endfunction : atValue

	always_comb begin
		wrMode = isWr(bus, OFF_MODE);
		wrCtrl = isWr(bus, OFF_CTRL);
		wrPeriod = isWr(bus, OFF_PERIOD);
		wrStatus = isWr(bus, OFF_STATUS);
	end

	// Event detection on a counting tick; match compares the live count
	always_comb begin
		// A held counter still compares, so a held match keeps its flag set
		countTick = tick && ctrl_q[CTRL_RUN];
		hitMatch = countTick && atValue(cnt_q, period_q);
		hitOvf = countTick && atValue(cnt_q, ALL_ONES);
		// Held at zero while an uncleared match waits in clear mode
		matchHold = !mode_q[MODE_MCD] && match_q;
	end

	// Counter next value; clear wins over hold wins over counting
	always_comb begin
		cnt_d = cnt_q;
		if (ctrl_q[CTRL_CLR]) begin
			cnt_d = '0;
		end else if (hitMatch && !mode_q[MODE_MCD]) begin
			cnt_d = '0;
		end else if (matchHold) begin
			cnt_d = '0;
		end else if (countTick && !ctrl_q[CTRL_HOLD]) begin
			// Wraps to zero past all ones; the overflow flag records it
			cnt_d = cnt_q + 1'b1;
		end
	end

	// Counter register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Setup values; only the low mode bits in use are kept
	always_comb begin
		mode_d = mode_q;
		period_d = period_q;
		if (wrMode) begin
			mode_d = {5'h00, bus.wdata[MODE_MCD:MODE_MIE]};
		end
		if (wrPeriod) begin
			period_d = bus.wdata;
		end
	end

	// Setup registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= RST_BYTE;
			period_q <= RST_WORD;
		end else begin
			mode_q <= mode_d;
			period_q <= period_d;
		end
	end

	// Control bits; clear is a one-shot action
	always_comb begin
		ctrl_d = ctrl_q;
		if (wrCtrl) begin
			ctrl_d = bus.wdata[CTRL_REQ:CTRL_RUN];
		end else begin
			ctrl_d[CTRL_CLR] = 1'b0;
			// Request falls once acknowledge is up; a stale one drops it unserved
			if (ack_q) begin
				ctrl_d[CTRL_REQ] = 1'b0;
			end
		end
	end

	// Control register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Snapshot once per request, so software reads a steady word
	always_comb begin
		snap_d = snap_q;
		if (ctrl_q[CTRL_REQ] && !ack_q) begin
			snap_d = 32'(cnt_q);
		end
	end

	// Snapshot register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			snap_q <= RST_WORD;
		end else begin
			snap_q <= snap_d;
		end
	end

	// Sticky flags; a set in the same cycle beats a write-one clear
	always_comb begin
		match_d = match_q;
		ovf_d = ovf_q;
		ack_d = ack_q;
		if (wrStatus && bus.wdata[ST_MATCH]) match_d = 1'b0;
		if (wrStatus && bus.wdata[ST_OVF]) ovf_d = 1'b0;
		if (wrStatus && bus.wdata[ST_ACK]) ack_d = 1'b0;
		if (hitMatch) match_d = 1'b1;
		if (hitOvf) ovf_d = 1'b1;
		if (ctrl_q[CTRL_REQ] && !ack_q) ack_d = 1'b1;
	end

	// Flag registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			match_q <= 1'b0;
			ovf_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			match_q <= match_d;
			ovf_q <= ovf_d;
			ack_q <= ack_d;
		end
	end

	// Interrupt and wakeup follow the next flag values, so they change on the same clock as the flags
	always_comb begin
		irq_d = (match_d && mode_q[MODE_MIE]) || (ovf_d && mode_q[MODE_OVERFLOW_IRQ_ENABLE]);
		wake_d = match_d || ovf_d;
	end

	// Event outputs, registered so they never glitch
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
			wakeup <= 1'b0;
		end else begin
			irq <= irq_d;
			wakeup <= wake_d;
		end
	end

	// Read mux; data valid in the cycle after the strobe
	always_comb begin
		rdata_d = RST_WORD;
		if (bus.rd) begin
			unique case (bus.addr)
				OFF_MODE: rdata_d = {24'h00_0000, mode_q};
				OFF_CTRL: rdata_d = {28'h000_0000, ctrl_q};
				OFF_PERIOD: rdata_d = period_q;
				OFF_COUNT: rdata_d = snap_q;
				OFF_STATUS: rdata_d = {29'h0000_0000, ack_q, ovf_q, match_q};
				default: rdata_d = RST_WORD;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= RST_WORD;
		end else begin
			rdata <= rdata_d;
		end
	end
endmodule : frt_timer

// *** testbench/frt_timer_chk.sv ***
// Port checker for the match timer
`timescale 1ns/1ps
module frt_timer_chk #(
	parameter int CNT_WIDTH = 32
) (
	// Clock, reset and tick
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic              tick,
	// Register bus
	input wire frt_pkg::frt_bus_t bus,
	input wire logic [31:0]       rdata,
	// Events
	input wire logic              irq,
	input wire logic              wakeup
);
	import frt_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence rdOf(logic [7:0] a);
		bus.rd && bus.addr == a;
	endsequence
	// Tick kept quiet so no new set races the clear
	sequence clrAll;
		(bus.wr && bus.addr == 8'h10 && bus.wdata[1:0] == 2'b11 && !tick) ##1 !tick[*2];
	endsequence
	a_idle_rdata: assert property (!bus.rd |=> rdata == 0)
		else $error("rdata idle");
	a_mode_upper: assert property (rdOf(8'h00) |=> rdata[31:3] == 0)
		else $error("mode bits");
	a_ctrl_upper: assert property (rdOf(8'h04) |=> rdata[31:4] == 0)
		else $error("ctrl bits");
	a_stat_upper: assert property (rdOf(8'h10) |=> rdata[31:3] == 0)
		else $error("status bits");
	a_irq_wake: assert property (irq |-> wakeup)
		else $error("irq alone");
	a_wake_cause: assert property ($rose(wakeup) |-> $past(tick))
		else $error("wakeup cause");
	a_irq_cause: assert property ($rose(irq) |-> $past(tick) || $past(bus.wr, 2))
		else $error("irq cause");
	a_clear_drop: assert property (clrAll |=> !wakeup)
		else $error("flags kept");
endmodule : frt_timer_chk
bind frt_timer frt_timer_chk #(.CNT_WIDTH(CNT_WIDTH)) frt_timer_chk_inst (.clock(clock),
	.rst_n(rst_n), .tick(tick), .bus(bus), .rdata(rdata), .irq(irq), .wakeup(wakeup));

// *** testbench/test_frt_timer.sv ***
// Self-checking bench for the match timer
`timescale 1ns/1ps
module test_frt_timer;
	import frt_pkg::*;
	logic        clock = 0, rst_n = 0, tick = 0, rdLast = 0, irq, wakeup;
	frt_bus_t    bus = '0;
	logic [31:0] rdata, r, q[$];
	logic [1:0]  evQ[$];
	logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
	int          errors = 0, checks = 0;
	// Narrow count so overflow comes quickly
	frt_timer #(.CNT_WIDTH(4)) frt_timer_inst (.clock(clock), .rst_n(rst_n), .tick(tick),
		.bus(bus), .rdata(rdata), .irq(irq), .wakeup(wakeup));
	always #20 clock = ~clock;
	task cmp(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task cmpEv(string n, logic e, logic g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %b got %b", n, e, g);
		end
	endtask : cmpEv
	// Gap cycle after each access avoids a double drive
	task acc(int w, logic [7:0] a, logic [31:0] d);
		bus <= '{w != 0, w == 0, a, d};
		if (w == 0) q.push_back(d);
		@(posedge clock);
		bus <= '0;
		@(posedge clock);
	endtask : acc
	// Read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		if (rdLast) cmp("rdata", q.pop_front(), rdata);
		if (evQ.size() > 0) begin
			cmpEv("irq", evQ[0][1], irq);
			cmpEv("wakeup", evQ[0][0], wakeup);
			void'(evQ.pop_front());
		end
		rdLast <= bus.rd;
	end
	task tk(int n);
		repeat (n) begin
			tick <= 1;
			@(posedge clock);
			tick <= 0;
			@(posedge clock);
		end
	endtask : tk
	// A stale acknowledge would drop the next request unserved, so it is cleared
	task snap(logic [31:0] c, logic [31:0] n, logic [31:0] s);
		acc(1, 8'h04, c);
		repeat (3) @(posedge clock);
		acc(0, 8'h10, s);
		acc(0, 8'h0C, n);
		acc(1, 8'h10, 4);
	endtask : snap
	// Levels are noted here and compared by the watcher
	task ev(int i, int w);
		repeat (3) @(posedge clock);
		evQ.push_back({i != 0, w != 0});
		@(posedge clock);
	endtask : ev
	task summarize;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	initial begin
		repeat (3000) @(posedge clock);
		errors++;
		summarize;
	end
	initial begin
		void'($urandom(18));
		repeat (12) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		foreach (offs[i]) acc(0, offs[i], 0);
		r = $urandom;
		acc(1, 8'h08, r);
		acc(0, 8'h08, r);
		acc(1, 8'h0C, 32'hFFFF_FFFF);
		tk(2);
		snap(8, 0, 4);
		acc(1, 8'h08, 3);
		acc(1, 8'h00, 5);
		acc(1, 8'h04, 1);
		tk(7);
		ev(1, 1);
		snap(9, 7, 5);
		acc(1, 8'h10, 4);
		acc(0, 8'h10, 1);
		acc(1, 8'h04, 3);
		tk(2);
		snap(11, 7, 5);
		acc(1, 8'h10, 7);
		acc(1, 8'h04, 1);
		tk(9);
		ev(0, 1);
		acc(0, 8'h10, 2);
		acc(1, 8'h00, 7);
		ev(1, 1);
		acc(1, 8'h10, 2);
		ev(0, 0);
		acc(1, 8'h00, 1);
		tk(6);
		snap(9, 0, 5);
		acc(1, 8'h10, 5);
		tk(2);
		snap(9, 2, 4);
		acc(1, 8'h04, 5);
		snap(9, 0, 4);
		summarize;
	end
endmodule : test_frt_timer
